// ==== cic_pkg.sv ====
// constants for the cascadable eight-line interrupt controller: port map, word fields, timing.
// assumes a 200 MHz core clock and a one-bit port select taken from address bit 1.
`default_nettype none

package cic_pkg;

  // ****************************************
  // port map
  // ****************************************
  localparam logic [7:0] MASTER_PORT_ZERO_OFS = 8'h00;
  localparam logic [7:0] MASTER_PORT_ONE_OFS = 8'h02;
  localparam logic [7:0] SLAVE_PORT_ZERO_OFS = 8'h04;
  localparam logic [7:0] SLAVE_PORT_ONE_OFS = 8'h06;
  localparam int PORT_SEL_ADDR_BIT = 1;

  // ****************************************
  // word fields
  // ****************************************
  localparam int MODE_FOURTH_WORD_BIT = 0;
  localparam int MODE_SINGLE_BIT = 1;
  localparam int MODE_LEVEL_BIT = 3;
  localparam int CMD_INIT_MARK_BIT = 4;
  localparam int CMD_SELECT_MARK_BIT = 3;
  localparam int CMD_SELECT_ZERO_BIT = 7;
  localparam int NEST_AUTO_EOI_BIT = 1;
  localparam int NEST_SPECIAL_BIT = 4;
  localparam int SEL_READ_SELECT_BIT = 0;
  localparam int SEL_READ_ENABLE_BIT = 1;
  localparam int SEL_SPECIAL_MASK_BIT = 5;
  localparam int SEL_SPECIAL_ENABLE_BIT = 6;
  localparam int EOI_CODE_LSB = 5;
  localparam logic [2:0] EOI_CODE_NONSPECIFIC = 3'h1;
  localparam logic [2:0] EOI_CODE_SPECIFIC = 3'h3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  localparam logic [2:0] SLAVE_ADDR_AT_INIT = 3'h7;
  localparam logic [2:0] SPURIOUS_LINE = 3'h7;
  localparam logic [2:0] CASCADE_IDLE = 3'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int REARM_LOW_TIME_NS = 100;
  localparam int REARM_LOW_CYCLES = (REARM_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    CIC_UNINIT, CIC_WAIT_BASE, CIC_WAIT_CASCADE, CIC_WAIT_NEST, CIC_READY
  } cic_init_type;

  typedef enum logic [1:0] {
    CIC_ACK_IDLE, CIC_ACK_SECOND, CIC_ACK_DONE
  } cic_ack_type;

endpackage : cic_pkg

`default_nettype wire

// ==== cic_top.sv ====
// eight-line priority interrupt controller, master or slave, with cascade bus and two-port registers.
// assumes the core drives strobes and acknowledge pulses on clk; request lines are asynchronous pins.
`default_nettype none

module cic_top
  import cic_pkg::*;
#(
  parameter int REARM_CYCLES = cic_pkg::REARM_LOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_select,
  input wire logic port_select,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] write_data,
  output logic [7:0] read_data,
  input wire logic [7:0] request_line_n,
  output logic interrupt_out,
  input wire logic acknowledge_pulse,
  output logic [7:0] type_out,
  output logic type_valid,
  input wire logic [2:0] cascade_bus_in,
  output logic [2:0] cascade_bus_out,
  output logic cascade_bus_oe,
  output logic init_done
);
  import cic_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (REARM_CYCLES < 1 || REARM_CYCLES > 31) begin : g_bad_rearm
    $error("REARM_CYCLES must be 1 to 31");
  end

  // ****************************************
  // helpers
  // ****************************************
  // highest priority set bit; line 7 ranks first after initialization
  function automatic logic [2:0] pick_top(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : pick_top

  // ****************************************
  // request pin synchroniser
  // ****************************************
  logic [7:0] line_meta;
  logic [7:0] line_sync;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_meta <= BYTE_CLEAR;
      line_sync <= BYTE_CLEAR;
    end else begin
      line_meta <= request_line_n;
      line_sync <= line_meta;
    end
  end

  // ****************************************
  // control state declarations
  // ****************************************
  cic_init_type init_state, next_init_state;
  cic_ack_type ack_state, next_ack_state;
  logic [7:0] mode_word, next_mode_word;
  logic [7:0] base_type, next_base_type;
  logic [7:0] cascade_word, next_cascade_word;
  logic [7:0] nest_word, next_nest_word;
  logic [7:0] mask, next_mask;
  logic [7:0] in_service, next_in_service;
  logic [7:0] pending, next_pending;
  logic read_select, next_read_select;
  logic special_mask, next_special_mask;
  logic [2:0] ack_line, next_ack_line;
  logic ack_spurious, next_ack_spurious;
  logic ack_answer, next_ack_answer;
  logic [7:0] next_read_data;
  logic next_interrupt_out;
  logic [7:0] next_type_out;
  logic next_type_valid;
  logic [2:0] next_cascade_bus_out;
  logic next_cascade_bus_oe;
  logic init_restart;
  logic [7:0] edge_hit;

  // ****************************************
  // edge detectors with low-time rearm
  // ****************************************
  // a line must sit low for the whole rearm time before a rise counts again;
  // shorter dips are taken as glitches of a held line
  for (genvar g = 0; g < 8; g++) begin : g_edge
    logic armed, next_armed;
    logic [4:0] low_count, next_low_count;

    always_comb begin
      next_armed = armed;
      next_low_count = low_count;
      edge_hit[g] = 1'b0;
      if (init_restart) begin
        next_armed = 1'b0;
        next_low_count = 5'h00;
      end else if (line_sync[g]) begin
        next_low_count = 5'h00;
        if (armed) begin
          edge_hit[g] = 1'b1;
          next_armed = 1'b0;
        end
      end else if (low_count >= 5'(REARM_CYCLES - 1)) begin
        next_armed = 1'b1;
      end else begin
        next_low_count = low_count + 5'h01;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        armed <= 1'b0;
        low_count <= 5'h00;
      end else begin
        armed <= next_armed;
        low_count <= next_low_count;
      end
    end
  end

  // ****************************************
  // priority resolution
  // ****************************************
  logic level_mode;
  logic is_cascaded_master;
  logic [7:0] live_service;
  logic [7:0] eligible;
  logic [2:0] best_line;
  logic slave_matched;

  // special mask drops masked in-service lines from blocking others
  always_comb begin
    level_mode = mode_word[MODE_LEVEL_BIT];
    is_cascaded_master = master_select && !mode_word[MODE_SINGLE_BIT];
    live_service = special_mask ? (in_service & ~mask) : in_service;
    for (int i = 0; i < 8; i++) begin
      logic blocked;
      blocked = 1'b0;
      for (int j = i + 1; j < 8; j++) begin
        blocked = blocked | live_service[j];
      end
      // special fully nested lets a slave line interrupt its own service
      if (live_service[i] && !(nest_word[NEST_SPECIAL_BIT] && is_cascaded_master && cascade_word[i])) begin
        blocked = 1'b1;
      end
      eligible[i] = pending[i] & ~mask[i] & ~blocked;
    end
    best_line = pick_top(eligible);
    slave_matched = (cascade_bus_in == cascade_word[2:0]);
  end

  // ****************************************
  // register port, initialization and acknowledge
  // ****************************************
  // one process owns every control register except pending, so that set and clear meet in one place
  always_comb begin
    logic [7:0] raise;
    logic [7:0] drop;
    logic [2:0] eoi_code;
    logic [2:0] line;
    next_init_state = init_state;
    next_ack_state = ack_state;
    next_mode_word = mode_word;
    next_base_type = base_type;
    next_cascade_word = cascade_word;
    next_nest_word = nest_word;
    next_mask = mask;
    next_in_service = in_service;
    next_read_select = read_select;
    next_special_mask = special_mask;
    next_ack_line = ack_line;
    next_ack_spurious = ack_spurious;
    next_ack_answer = ack_answer;
    next_read_data = read_data;
    next_type_out = type_out;
    next_type_valid = 1'b0;
    next_cascade_bus_out = cascade_bus_out;
    next_cascade_bus_oe = cascade_bus_oe;
    init_restart = 1'b0;
    raise = BYTE_CLEAR;
    drop = BYTE_CLEAR;
    eoi_code = write_data[EOI_CODE_LSB +: 3];
    line = 3'h0;

    // writes: port select is address bit 1 of the core
    if (write_strobe) begin
      if (!port_select && write_data[CMD_INIT_MARK_BIT]) begin
        init_restart = 1'b1;
        next_mode_word = write_data;
        next_init_state = CIC_WAIT_BASE;
        next_mask = BYTE_CLEAR;
        next_special_mask = 1'b0;
        next_read_select = 1'b0;
        next_cascade_word = {5'h00, SLAVE_ADDR_AT_INIT};
        next_nest_word = BYTE_CLEAR;
        next_ack_state = CIC_ACK_IDLE;
        next_cascade_bus_oe = 1'b0;
      end else if (port_select) begin
        case (init_state)
          CIC_WAIT_BASE: begin
            next_base_type = write_data;
            if (!mode_word[MODE_SINGLE_BIT]) begin
              next_init_state = CIC_WAIT_CASCADE;
            end else if (mode_word[MODE_FOURTH_WORD_BIT]) begin
              next_init_state = CIC_WAIT_NEST;
            end else begin
              next_init_state = CIC_READY;
            end
          end
          CIC_WAIT_CASCADE: begin
            next_cascade_word = write_data;
            next_init_state = mode_word[MODE_FOURTH_WORD_BIT] ? CIC_WAIT_NEST : CIC_READY;
          end
          CIC_WAIT_NEST: begin
            next_nest_word = write_data;
            next_init_state = CIC_READY;
          end
          CIC_READY: begin
            next_mask = write_data;
          end
          default: begin
            next_init_state = init_state;
          end
        endcase
      end else if (init_state == CIC_READY) begin
        if (!write_data[CMD_SELECT_MARK_BIT]) begin
          // end-of-interrupt command; other codes are not decoded here
          if (eoi_code == EOI_CODE_NONSPECIFIC) begin
            drop[pick_top(in_service)] = 1'b1;
          end else if (eoi_code == EOI_CODE_SPECIFIC) begin
            drop[write_data[2:0]] = 1'b1;
          end
        end else if (!write_data[CMD_SELECT_ZERO_BIT]) begin
          if (write_data[SEL_READ_ENABLE_BIT]) begin
            next_read_select = write_data[SEL_READ_SELECT_BIT];
          end
          if (write_data[SEL_SPECIAL_ENABLE_BIT]) begin
            next_special_mask = write_data[SEL_SPECIAL_MASK_BIT];
          end
        end
      end
    end

    // reads: data answers one cycle after the strobe
    if (read_strobe) begin
      if (init_state != CIC_READY) begin
        next_read_data = BYTE_CLEAR;
      end else if (port_select) begin
        next_read_data = mask;
      end else begin
        next_read_data = read_select ? in_service : pending;
      end
    end

    // acknowledge: first pulse resolves (a master commits here), second pulse hands over the type and commits on a slave
    if (!init_restart && init_state == CIC_READY) begin
      case (ack_state)
        CIC_ACK_IDLE: begin
          if (acknowledge_pulse) begin
            line = (|eligible) ? best_line : SPURIOUS_LINE;
            next_ack_line = line;
            next_ack_spurious = ~|eligible;
            next_ack_state = CIC_ACK_SECOND;
            if (master_select) begin
              next_ack_answer = !(is_cascaded_master && cascade_word[line]);
              next_cascade_bus_out = next_ack_answer ? CASCADE_IDLE : line;
              next_cascade_bus_oe = is_cascaded_master;
              if (|eligible) begin
                raise[line] = 1'b1;
              end
            end else begin
              next_ack_answer = 1'b0;
            end
          end
        end
        CIC_ACK_SECOND: begin
          if (acknowledge_pulse) begin
            next_ack_state = CIC_ACK_DONE;
            if (master_select ? ack_answer : slave_matched) begin
              next_type_out = base_type + {5'h00, ack_line};
              next_type_valid = 1'b1;
            end
            // a slave commits only when the master addressed it
            if (!master_select && slave_matched && !ack_spurious) begin
              raise[ack_line] = 1'b1;
            end
            if (nest_word[NEST_AUTO_EOI_BIT] && !ack_spurious &&
                (master_select || slave_matched)) begin
              drop[ack_line] = 1'b1;
            end
          end
        end
        CIC_ACK_DONE: begin
          next_ack_state = CIC_ACK_IDLE;
          next_cascade_bus_oe = 1'b0;
          next_cascade_bus_out = CASCADE_IDLE;
        end
        default: begin
          next_ack_state = CIC_ACK_IDLE;
        end
      endcase
    end
    next_in_service = (in_service | raise) & ~(drop & ~raise);
    next_interrupt_out = (init_state == CIC_READY) && (ack_state == CIC_ACK_IDLE) &&
                         !acknowledge_pulse && (|eligible);
  end

  // ****************************************
  // pending requests
  // ****************************************
  // a new edge in the cycle of a clearing read or acknowledge is kept
  always_comb begin
    logic [7:0] clear;
    logic [7:0] arrive;
    clear = BYTE_CLEAR;
    arrive = level_mode ? line_sync : edge_hit;
    if (read_strobe && !port_select && !read_select && init_state == CIC_READY) begin
      clear = 8'hff;
    end
    if (init_state == CIC_READY && ack_state == CIC_ACK_IDLE && acknowledge_pulse && |eligible &&
        master_select) begin
      clear[best_line] = 1'b1;
    end
    if (ack_state == CIC_ACK_SECOND && acknowledge_pulse && !master_select && slave_matched &&
        !ack_spurious) begin
      clear[ack_line] = 1'b1;
    end
    if (init_restart) begin
      clear = 8'hff;
    end
    // level mode tracks the line, so a line still high after service asks again;
    // a clear there drops only bits already latched, a fresh arrival is kept
    next_pending = (pending & ~clear) | arrive;
    if (level_mode) begin
      next_pending = arrive & ~(clear & pending);
    end
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= CIC_UNINIT;
      ack_state <= CIC_ACK_IDLE;
      mode_word <= BYTE_CLEAR;
      base_type <= BYTE_CLEAR;
      cascade_word <= BYTE_CLEAR;
      nest_word <= BYTE_CLEAR;
      mask <= BYTE_CLEAR;
      in_service <= BYTE_CLEAR;
      pending <= BYTE_CLEAR;
      read_select <= 1'b0;
      special_mask <= 1'b0;
      ack_line <= 3'h0;
      ack_spurious <= 1'b0;
      ack_answer <= 1'b0;
      read_data <= BYTE_CLEAR;
      interrupt_out <= 1'b0;
      type_out <= BYTE_CLEAR;
      type_valid <= 1'b0;
      cascade_bus_out <= CASCADE_IDLE;
      cascade_bus_oe <= 1'b0;
      init_done <= 1'b0;
    end else begin
      init_state <= next_init_state;
      ack_state <= next_ack_state;
      mode_word <= next_mode_word;
      base_type <= next_base_type;
      cascade_word <= next_cascade_word;
      nest_word <= next_nest_word;
      mask <= next_mask;
      in_service <= next_in_service;
      pending <= next_pending;
      read_select <= next_read_select;
      special_mask <= next_special_mask;
      ack_line <= next_ack_line;
      ack_spurious <= next_ack_spurious;
      ack_answer <= next_ack_answer;
      read_data <= next_read_data;
      interrupt_out <= next_interrupt_out;
      type_out <= next_type_out;
      type_valid <= next_type_valid;
      cascade_bus_out <= next_cascade_bus_out;
      cascade_bus_oe <= next_cascade_bus_oe;
      init_done <= (next_init_state == CIC_READY);
    end
  end

endmodule : cic_top

`default_nettype wire

// ==== cic_chk.sv ====
// checker on the top-level ports of the interrupt controller.
// assumes one clock domain and the registered timing of the port protocol.
`default_nettype none

module cic_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_select,
  input wire logic port_select,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] write_data,
  input wire logic [7:0] read_data,
  input wire logic interrupt_out,
  input wire logic acknowledge_pulse,
  input wire logic type_valid,
  input wire logic cascade_bus_oe,
  input wire logic init_done
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ************
  // sequences
  // ************
  // first pulse of an acknowledge while a request is offered
  sequence s_first_ack;
    acknowledge_pulse && interrupt_out;
  endsequence
  sequence s_mode_word;
    write_strobe && !port_select && write_data[4];
  endsequence

  // ************
  // assertions
  // ************
  // a mode word always restarts, even mid-run
  a_mode_word_restart: assert property (s_mode_word |=> !init_done)
    else $error("mode word did not restart init");
  a_init_ends_port1: assert property ($rose(init_done) |-> $past(write_strobe && port_select))
    else $error("init ended without a port 1 write");
  a_quiet_uninit: assert property (!init_done && $past(!init_done) |-> !interrupt_out)
    else $error("interrupt while uninitialized");
  a_uninit_read_zero: assert property (read_strobe && !init_done |=> read_data == 8'h00)
    else $error("read before init not zero");
  a_ack_drops_int: assert property (s_first_ack |=> !interrupt_out)
    else $error("interrupt held after first pulse");
  a_type_one_cycle: assert property (type_valid |=> !type_valid)
    else $error("type valid longer than one cycle");
  a_type_after_ack: assert property ($rose(type_valid) |-> $past(acknowledge_pulse))
    else $error("type given without a pulse");
  a_oe_master_only: assert property (cascade_bus_oe |-> master_select)
    else $error("slave drives the cascade bus");
  a_oe_bounded: assert property ($rose(cascade_bus_oe) |-> $past(acknowledge_pulse) ##[1:8] !cascade_bus_oe)
    else $error("cascade drive not tied to acknowledge");
endmodule : cic_chk

bind cic_top cic_chk i_cic_chk (
  .clk, .rst_n, .master_select, .port_select, .write_strobe, .read_strobe, .write_data,
  .read_data, .interrupt_out, .acknowledge_pulse, .type_valid, .cascade_bus_oe, .init_done
);

`default_nettype wire

// ==== cic_core_model.sv ====
// behavioural core on the acknowledge side: answers an offered request with two pulses.
// assumes the controller's registered interrupt and type outputs on the same clock.
`default_nettype none

module cic_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interrupt_out,
  input wire logic type_valid,
  input wire logic [7:0] type_out,
  input wire logic [2:0] cascade_bus_out,
  input wire logic [7:0] delay,
  output logic acknowledge_pulse,
  output logic [7:0] last_type,
  output logic [2:0] last_cas,
  output int acks
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************
  // acknowledge
  // ************
  // a slow core (delay) lets the request vanish before the first pulse
  initial begin
    acknowledge_pulse = 1'b0;
    last_type = 8'h00;
    last_cas = 3'h0;
    acks = 0;
    forever begin
      @(posedge clk);
      #1;
      if (rst_n && interrupt_out === 1'b1) begin
        // zero stays if nobody answers, so a silent master shows up
        last_type = 8'h00;
        repeat (delay) @(posedge clk);
        #1;
        acknowledge_pulse = 1'b1;
        @(posedge clk) #1;
        acknowledge_pulse = 1'b0;
        // cascade bus is driven from the edge that took the first pulse
        last_cas = cascade_bus_out;
        @(posedge clk) #1;
        acknowledge_pulse = 1'b1;
        @(posedge clk) #1;
        acknowledge_pulse = 1'b0;
        // gap after the second pulse also leaves room for the type
        repeat (4) begin
          @(negedge clk);
          if (type_valid === 1'b1) begin
            last_type = type_out;
          end
        end
        acks++;
      end
    end
  end
endmodule : cic_core_model

`default_nettype wire

// ==== tb.sv ====
// self-checking bench: register traffic from tasks, core model on the acknowledge side.
// assumes a 200 MHz clock and one-cycle strobes on the two-port interface.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, port_select, write_strobe, read_strobe, interrupt_out;
  logic type_valid, cascade_bus_oe, init_done, ack;
  logic [7:0] write_data, read_data, request_line_n, type_out, delay, m_type;
  logic [2:0] cascade_bus_out, m_cas, cascade_bus_in;
  logic master_select;
  int acks, ack_cnt, fail_count, num_checks;

  // short rearm count keeps the edge tests brief
  cic_top #(.REARM_CYCLES(2)) i_cic_top (
    .clk(clk), .rst_n(rst_n), .master_select(master_select), .port_select(port_select),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .write_data(write_data),
    .read_data(read_data), .request_line_n(request_line_n), .interrupt_out(interrupt_out),
    .acknowledge_pulse(ack), .type_out(type_out), .type_valid(type_valid),
    .cascade_bus_in(cascade_bus_in), .cascade_bus_out(cascade_bus_out), .cascade_bus_oe(cascade_bus_oe),
    .init_done(init_done)
  );

  cic_core_model i_cic_core_model (
    .clk(clk), .rst_n(rst_n), .interrupt_out(interrupt_out), .type_valid(type_valid),
    .type_out(type_out), .cascade_bus_out(cascade_bus_out), .delay(delay),
    .acknowledge_pulse(ack), .last_type(m_type), .last_cas(m_cas), .acks(acks)
  );

  // ************
  // tasks
  // ************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic p, input logic [7:0] d);
    @(posedge clk) #1;
    port_select = p;
    write_data = d;
    write_strobe = 1'b1;
    @(posedge clk) #1;
    write_strobe = 1'b0;
  endtask : wr

  task automatic rd(input logic p, input logic [7:0] exp);
    @(posedge clk) #1;
    port_select = p;
    read_strobe = 1'b1;
    @(posedge clk) #1;
    read_strobe = 1'b0;
    chk(read_data, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // bounded wait for the model to finish one more acknowledge
  task automatic wait_ack(input logic [7:0] et);
    int i;
    ack_cnt++;
    for (i = 0; i < 300 && acks < ack_cnt; i++) @(posedge clk);
    #1;
    if (acks < ack_cnt) begin
      fail_count++;
      $display("ERROR %0t: no acknowledge", $time);
      tally_and_finish();
    end
    else chk(m_type, et);
  endtask : wait_ack

  // ************
  // stimulus
  // ************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    master_select = 1'b1;
    cascade_bus_in = 3'h0;
    port_select = 1'b0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    write_data = 8'h00;
    request_line_n = 8'h00;
    delay = 8'h00;
    ack_cnt = 0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(1'b1, 8'h00);
    // edge mode, cascaded, fourth word needed, slave on line 7
    wr(1'b0, 8'h11);
    wr(1'b1, 8'h60);
    wr(1'b1, 8'h80);
    wr(1'b1, 8'h00);
    tick(1);
    chk({7'h0, init_done}, 8'h01);
    rd(1'b1, 8'h00);
    wr(1'b1, 8'hff);
    rd(1'b1, 8'hff);
    request_line_n = 8'h04;
    tick(10);
    chk({7'h0, interrupt_out}, 8'h00);
    wr(1'b1, 8'h00);
    wait_ack(8'h62);
    chk({5'h0, m_cas}, 8'h00);
    wr(1'b0, 8'h0b);
    rd(1'b0, 8'h04);
    wr(1'b0, 8'h08);
    rd(1'b0, 8'h04);
    wr(1'b0, 8'h0a);
    rd(1'b0, 8'h00);
    wr(1'b0, 8'h20);
    tick(10);
    chk({7'h0, interrupt_out}, 8'h00);
    request_line_n = 8'h00;
    tick(8);
    request_line_n = 8'h04;
    wait_ack(8'h62);
    wr(1'b0, 8'h20);
    // lines 1 and 4 rise together: 4 wins, 1 waits until the pending read clears it
    request_line_n = 8'h16;
    wait_ack(8'h64);
    tick(5);
    rd(1'b0, 8'h02);
    wr(1'b0, 8'h20);
    tick(10);
    chk({7'h0, interrupt_out}, 8'h00);
    // slave behind line 7: master names it on the cascade bus and keeps quiet
    request_line_n = 8'h96;
    wait_ack(8'h00);
    chk({5'h0, m_cas}, 8'h07);
    wr(1'b0, 8'h20);
    // level mode restart
    request_line_n = 8'h00;
    tick(10);
    wr(1'b0, 8'h19);
    wr(1'b1, 8'h68);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h00);
    // slow core: line gone before the first pulse
    delay = 8'd30;
    request_line_n = 8'h08;
    tick(10);
    request_line_n = 8'h00;
    wait_ack(8'h6f);
    delay = 8'h00;
    wr(1'b0, 8'h0b);
    rd(1'b0, 8'h00);
    request_line_n = 8'h40;
    wait_ack(8'h6e);
    tick(20);
    chk(acks[7:0], ack_cnt[7:0]);
    rd(1'b0, 8'h40);
    wr(1'b0, 8'h20);
    wait_ack(8'h6e);
    request_line_n = 8'h00;
    tick(20);
    wr(1'b0, 8'h66);
    rd(1'b0, 8'h00);
    // single controller with automatic end-of-interrupt: no cascade word taken
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h60);
    wr(1'b1, 8'h02);
    tick(1);
    chk({7'h0, init_done}, 8'h01);
    wr(1'b0, 8'h0b);
    request_line_n = 8'h20;
    wait_ack(8'h65);
    rd(1'b0, 8'h00);
    // second reset: the same block as the slave with identifier 3
    request_line_n = 8'h00;
    rst_n = 1'b0;
    master_select = 1'b0;
    cascade_bus_in = 3'h3;
    tick(3);
    rst_n = 1'b1;
    rd(1'b1, 8'h00);
    wr(1'b0, 8'h11);
    wr(1'b1, 8'h70);
    wr(1'b1, 8'h03);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h0b);
    request_line_n = 8'h20;
    wait_ack(8'h75);
    rd(1'b0, 8'h20);
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
